/* rtl/fglr_pkg.sv */
// Package for the flash global lock and software reset command block
package fglr_pkg;

  // Opcodes
  localparam logic [7:0] OP_GLOBAL_LOCK   = 8'h7e;
  localparam logic [7:0] OP_GLOBAL_UNLOCK = 8'h98;
  localparam logic [7:0] OP_RESET_ENABLE  = 8'h66;
  localparam logic [7:0] OP_RESET         = 8'h99;
  localparam logic [7:0] OP_WRITE_ENABLE  = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;

  // Register map (byte addresses)
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_LOCK0  = 8'h08;
  localparam logic [7:0] ADDR_CMD    = 8'h0c;

  // Control register fields
  localparam int CTRL_SCHEME_BIT  = 0;
  localparam int CTRL_SUSPEND_BIT = 1;
  localparam int CTRL_BUSY_BIT  = 2;
  localparam int CTRL_PARAM_LSB = 8;
  localparam int CTRL_MODE_LSB  = 16;
  localparam int CTRL_WRAP_LSB  = 24;

  // Status register fields
  localparam int STAT_WRITE_EN_BIT = 0;
  localparam int STAT_ARMED_BIT  = 1;
  localparam int STAT_RST_BIT    = 2;
  localparam int STAT_DROP_BIT   = 3;

  // Reset values
  localparam logic [7:0] PARAM_RESET = 8'h00;
  localparam logic [7:0] MODE_RESET  = 8'h00;
  localparam logic [2:0] WRAP_RESET  = 3'h0;

  // Reset recovery time
  localparam int CLK_MHZ        = 200;
  localparam int RESET_RECOV_US = 30;
  localparam int RESET_RECOV_CYC = RESET_RECOV_US * CLK_MHZ;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // SPI pins seen by the device
  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic serial_data_in;
  } fglr_spi_s;

  // Opcode delivered by the shifter
  typedef struct packed {
    logic       valid;
    logic [7:0] code;
  } fglr_op_s;

endpackage

/* rtl/fglr_shifter.sv */
// Serial opcode shifter: frames one opcode per chip select assertion
`timescale 1ns/100ps
`default_nettype none
module fglr_shifter
(
  // Clock and reset
  input  wire logic            aclk,
  input  wire logic            aresetn,
  // Serial pins
  input  wire fglr_pkg::fglr_spi_s spi,
  // Decoded opcode
  output var fglr_pkg::fglr_op_s op
);

  typedef struct packed {
    logic       sclk_d;
    logic [3:0] count;
    logic [7:0] shreg;
    logic       cs_d;
    fglr_pkg::fglr_op_s op;
  } fglr_shift_s;

  fglr_shift_s st;
  fglr_shift_s next_st;

  always_comb
  begin
    next_st          = st;
    next_st.sclk_d   = spi.sclk;
    next_st.cs_d     = spi.cs_n;
    next_st.op.valid = 1'b0;
    if (spi.cs_n)
    begin
      // Only a frame of exactly eight bits counts as a command
      if (!st.cs_d && st.count == 4'd8)
      begin
        next_st.op.valid = 1'b1;
        next_st.op.code  = st.shreg;
      end
      next_st.count = 4'd0;
    end
    else if (spi.sclk && !st.sclk_d)
    begin
      next_st.shreg = {st.shreg[6:0], spi.serial_data_in};
      if (st.count != 4'hf)
      begin
        next_st.count = st.count + 4'd1;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st <= '{sclk_d: 1'b0, count: 4'd0, shreg: 8'h00, cs_d: 1'b1, op: '{valid: 1'b0, code: 8'h00}};
    end
    else
    begin
      st <= next_st;
    end
  end

  assign op = st.op;

endmodule
`default_nettype wire

/* rtl/fglr_cmd.sv */
// Global lock/unlock and two-step software reset command interpreter
// What this block does
// - Global lock opcode 7Eh sets every protection bit to one.
// - Global unlock opcode 98h clears every protection bit to zero.
// - Global lock and unlock are accepted only while the write enable latch is set.
// - An accepted reset aborts work and restores defaults of volatile state.
// - Reset happens only when 66h is directly followed by 99h.
// - Any command other than 99h or a repeated 66h after 66h disarms the reset.
// - All commands are ignored for about 30us after a reset.
// - Protection bits are volatile and read as one after power-up or reset.
// - Protection bits govern protection only when protect_scheme_select is one.
`timescale 1ns/100ps
`default_nettype none
module fglr_cmd
#(
  parameter int NUM_LOCKS     = 32,
  parameter int RECOVERY_CYC  = fglr_pkg::RESET_RECOV_CYC
)
(
  // Clock and reset
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  // Serial pins
  input  wire fglr_pkg::fglr_spi_s  spi,
  // Effective protection per block
  output logic [NUM_LOCKS-1:0]      block_protected,
  output logic                      reset_busy,
  // AXI4-Lite write address
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [7:0]           s_axi_awaddr,
  // AXI4-Lite write data
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  // AXI4-Lite write response
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  output logic [1:0]                s_axi_bresp,
  // AXI4-Lite read address
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  input  wire logic [7:0]           s_axi_araddr,
  // AXI4-Lite read data
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp
);

  localparam int CW = $clog2(RECOVERY_CYC + 1);

  typedef struct packed {
    logic [NUM_LOCKS-1:0] locks;
    logic                 write_enable_latch;
    logic                 armed;
    logic [CW-1:0]        recov;
    logic                 dropped;
    logic                 protect_scheme_select;
    logic                 suspend_flag;
    logic                 busy;
    logic [7:0]           read_parameter_bits;
    logic [7:0]           continuous_read_mode_bits;
    logic [2:0]           wrap_setting_bits;
    logic                 aw_got;
    logic [7:0]           aw_addr;
    logic                 w_got;
    logic [31:0]          w_data;
    logic [3:0]           w_strb;
    logic                 bvalid;
    logic [1:0]           bresp;
    logic                 rvalid;
    logic [31:0]          rdata;
    logic [1:0]           rresp;
  } fglr_state_s;

  fglr_state_s st;
  fglr_state_s next_st;
  fglr_pkg::fglr_op_s op;
  fglr_pkg::fglr_op_s cmd;
  logic sw_cmd_hit;
  logic [7:0] sw_cmd_code;
  logic do_write;
  logic [31:0] ctrl_word;

  fglr_shifter u_shifter
  (
    .aclk    (aclk),
    .aresetn (aresetn),
    .spi     (spi),
    .op      (op)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Bus side helpers

  assign do_write = st.aw_got && st.w_got && !st.bvalid;
  // Software may inject an opcode through the command register, same path as the pins
  assign sw_cmd_hit  = do_write && st.aw_addr == fglr_pkg::ADDR_CMD && st.w_strb[0];
  assign sw_cmd_code = st.w_data[7:0];

  always_comb
  begin
    cmd = op;
    if (!op.valid && sw_cmd_hit)
    begin
      cmd.valid = 1'b1;
      cmd.code  = sw_cmd_code;
    end
  end

  assign ctrl_word = {5'h00, st.wrap_setting_bits, st.continuous_read_mode_bits,
                      st.read_parameter_bits, 5'h00, st.busy, st.suspend_flag, st.protect_scheme_select};

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb
  begin
    next_st = st;

    // Recovery countdown after a reset
    if (st.recov != '0)
    begin
      next_st.recov = st.recov - CW'(1);
    end

    if (cmd.valid)
    begin
      if (st.recov != '0)
      begin
        next_st.dropped = 1'b1;
      end
      else
      begin
        next_st.armed = 1'b0;
        case (cmd.code)
          fglr_pkg::OP_WRITE_ENABLE:
          begin
            next_st.write_enable_latch = 1'b1;
          end
          fglr_pkg::OP_WRITE_DISABLE:
          begin
            next_st.write_enable_latch = 1'b0;
          end
          fglr_pkg::OP_GLOBAL_LOCK:
          begin
            if (st.write_enable_latch)
            begin
              next_st.locks              = '1;
              next_st.write_enable_latch = 1'b0;
            end
            else
            begin
              next_st.dropped = 1'b1;
            end
          end
          fglr_pkg::OP_GLOBAL_UNLOCK:
          begin
            if (st.write_enable_latch)
            begin
              next_st.locks              = '0;
              next_st.write_enable_latch = 1'b0;
            end
            else
            begin
              next_st.dropped = 1'b1;
            end
          end
          fglr_pkg::OP_RESET_ENABLE:
          begin
            next_st.armed = 1'b1;
          end
          fglr_pkg::OP_RESET:
          begin
            if (st.armed)
            begin
              next_st.locks                     = '1;
              next_st.write_enable_latch        = 1'b0;
              next_st.suspend_flag              = 1'b0;
              next_st.busy                      = 1'b0;
              next_st.protect_scheme_select     = 1'b0;
              next_st.read_parameter_bits       = fglr_pkg::PARAM_RESET;
              next_st.continuous_read_mode_bits = fglr_pkg::MODE_RESET;
              next_st.wrap_setting_bits         = fglr_pkg::WRAP_RESET;
              next_st.recov                     = CW'(RECOVERY_CYC);
            end
          end
          default:
          begin
          end
        endcase
      end
    end

    // AXI4-Lite write channel capture
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_st.aw_got  = 1'b1;
      next_st.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_st.w_got  = 1'b1;
      next_st.w_data = s_axi_wdata;
      next_st.w_strb = s_axi_wstrb;
    end
    if (do_write)
    begin
      next_st.aw_got = 1'b0;
      next_st.w_got  = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp  = fglr_pkg::RESP_OKAY;
      case (st.aw_addr)
        fglr_pkg::ADDR_CTRL:
        begin
          if (st.w_strb[0])
          begin
            next_st.protect_scheme_select = st.w_data[fglr_pkg::CTRL_SCHEME_BIT];
            next_st.suspend_flag          = st.w_data[fglr_pkg::CTRL_SUSPEND_BIT];
            next_st.busy         = st.w_data[fglr_pkg::CTRL_BUSY_BIT];
          end
          if (st.w_strb[1])
          begin
            next_st.read_parameter_bits = st.w_data[fglr_pkg::CTRL_PARAM_LSB +: 8];
          end
          if (st.w_strb[2])
          begin
            next_st.continuous_read_mode_bits = st.w_data[fglr_pkg::CTRL_MODE_LSB +: 8];
          end
          if (st.w_strb[3])
          begin
            next_st.wrap_setting_bits = st.w_data[fglr_pkg::CTRL_WRAP_LSB +: 3];
          end
        end
        fglr_pkg::ADDR_STATUS:
        begin
          // Writing one clears the sticky drop flag; a drop landing now keeps it set only if it was clear
          if (st.w_strb[0] && st.w_data[fglr_pkg::STAT_DROP_BIT] && !(next_st.dropped && !st.dropped))
          begin
            next_st.dropped = 1'b0;
          end
        end
        fglr_pkg::ADDR_CMD, fglr_pkg::ADDR_LOCK0:
        begin
        end
        default:
        begin
          next_st.bresp = fglr_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (st.bvalid && s_axi_bready)
    begin
      next_st.bvalid = 1'b0;
    end

    // AXI4-Lite read channel
    if (s_axi_arvalid && s_axi_arready)
    begin
      next_st.rvalid = 1'b1;
      next_st.rresp  = fglr_pkg::RESP_OKAY;
      case (s_axi_araddr)
        fglr_pkg::ADDR_CTRL:
        begin
          next_st.rdata = ctrl_word;
        end
        fglr_pkg::ADDR_STATUS:
        begin
          next_st.rdata = {28'h0000000, st.dropped, st.recov != '0, st.armed, st.write_enable_latch};
        end
        fglr_pkg::ADDR_LOCK0:
        begin
          next_st.rdata = 32'(st.locks);
        end
        fglr_pkg::ADDR_CMD:
        begin
          next_st.rdata = 32'h00000000;
        end
        default:
        begin
          next_st.rdata = 32'h00000000;
          next_st.rresp = fglr_pkg::RESP_SLVERR;
        end
      endcase
    end
    else if (st.rvalid && s_axi_rready)
    begin
      next_st.rvalid = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st       <= '0;
      st.locks <= '1;
    end
    else
    begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Holding off new addresses while a response waits keeps one write in flight
  assign s_axi_awready = !st.aw_got && !st.bvalid;
  assign s_axi_wready  = !st.w_got && !st.bvalid;
  assign s_axi_bvalid  = st.bvalid;
  assign s_axi_bresp   = st.bresp;
  assign s_axi_arready = !st.rvalid;
  assign s_axi_rvalid  = st.rvalid;
  assign s_axi_rdata   = st.rdata;
  assign s_axi_rresp   = st.rresp;
  assign reset_busy    = st.recov != '0;

  // With the scheme bit clear the per-block bits have no effect
  assign block_protected = st.protect_scheme_select ? st.locks : '0;

endmodule
`default_nettype wire

/* sim/fglr_cmd_monitor.sv */
// Assertion checker for the global lock and software reset command block
`timescale 1ns/100ps
`default_nettype none
module fglr_cmd_monitor
#(
  parameter int NUM_LOCKS    = 32,
  parameter int RECOVERY_CYC = 6000
)
(
  // Clock, reset and pins
  input wire logic                 aclk,
  input wire logic                 aresetn,
  input wire fglr_pkg::fglr_spi_s  spi,
  // Observed outputs
  input wire logic [NUM_LOCKS-1:0] block_protected,
  input wire logic                 reset_busy
);
  logic       cs_q;
  logic       sclk_q;
  logic [3:0] cnt;
  logic [7:0] code;
  logic [7:0] prev_code;
  int         busy_cnt;
  logic       done;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Own opcode decode, so the checks do not lean on the shifter
  assign done = spi.cs_n && !cs_q && (cnt == 4'h8);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cs_q      <= 1'b1;
      sclk_q    <= 1'b0;
      cnt       <= 4'h0;
      code      <= 8'h00;
      prev_code <= 8'h00;
      busy_cnt  <= 0;
    end
    else
    begin
      cs_q     <= spi.cs_n;
      sclk_q   <= spi.sclk;
      busy_cnt <= reset_busy ? busy_cnt + 1 : 0;
      if (spi.cs_n)
        cnt <= 4'h0;
      else if (spi.sclk && !sclk_q && cnt != 4'hf)
      begin
        cnt  <= cnt + 4'h1;
        code <= {code[6:0], spi.serial_data_in};
      end
      if (done && !reset_busy)
        prev_code <= code;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  AST_LOCK_ALL: assert property (
    done && code == fglr_pkg::OP_GLOBAL_LOCK |->
    ##2 (block_protected == '1 || block_protected == $past(block_protected, 2)))
    else $error("global lock lowered protection");
  AST_UNLOCK_ALL: assert property (
    done && code == fglr_pkg::OP_GLOBAL_UNLOCK |->
    ##2 (block_protected == '0 || block_protected == $past(block_protected, 2)))
    else $error("global unlock raised protection");
  AST_BUSY_MIN: assert property ($rose(reset_busy) |=> reset_busy[*8])
    else $error("recovery ended too soon");
  AST_BUSY_MAX: assert property (busy_cnt <= RECOVERY_CYC + 2)
    else $error("recovery lasts too long");
  AST_BUSY_IGN: assert property (
    done && reset_busy && busy_cnt < RECOVERY_CYC - 4 |-> ##2 reset_busy)
    else $error("command during recovery ended it");
  AST_RST_PAIR: assert property (
    $rose(reset_busy) |-> $past(done, 2) && $past(code, 2) == fglr_pkg::OP_RESET
    && $past(prev_code, 2) == fglr_pkg::OP_RESET_ENABLE)
    else $error("reset without enable then reset pair");
  AST_RST_CANCEL: assert property (
    done && code == fglr_pkg::OP_RESET && prev_code != fglr_pkg::OP_RESET_ENABLE && !reset_busy
    |-> ##2 !reset_busy)
    else $error("reset taken without armed enable");
  AST_RST_PROT: assert property (reset_busy |-> block_protected == '0)
    else $error("scheme select survived reset");
endmodule
`default_nettype wire

/* sim/fglr_host.sv */
// SPI host model that frames single opcodes toward the device pins
`timescale 1ns/100ps
`default_nettype none
module fglr_host
(
  // Clock
  input  wire logic               aclk,
  // Pins toward the device
  output var fglr_pkg::fglr_spi_s spi
);
  logic busy = 1'b0;

  initial spi = '{cs_n: 1'b1, sclk: 1'b0, serial_data_in: 1'b0};

  // Released data line keeps moving so a stale bit is never mistaken for data
  always @(posedge aclk)
    if (!busy)
      spi.serial_data_in <= ~spi.serial_data_in;

  // Clock stands low outside frames; data changes while sclk is low
  task automatic send(input logic [7:0] op, input int nbits);
    busy <= 1'b1;
    @(posedge aclk);
    spi.cs_n <= 1'b0;
    for (int i = 0; i < nbits; i++)
    begin
      @(posedge aclk);
      spi.sclk           <= 1'b0;
      spi.serial_data_in <= op[7-i];
      @(posedge aclk);
      spi.sclk <= 1'b1;
    end
    @(posedge aclk);
    spi.sclk <= 1'b0;
    @(posedge aclk);
    spi.cs_n <= 1'b1;
    busy     <= 1'b0;
    repeat (3) @(posedge aclk);
  endtask
endmodule
`default_nettype wire

/* sim/tb_flash_global_lock_and_reset_cmds.sv */
// Self-checking bench for the global lock and software reset command block
`timescale 1ns/100ps
`default_nettype none
module tb_flash_global_lock_and_reset_cmds;
  // Short recovery, still longer than one opcode frame
  localparam int RC = 60;
  logic                aclk          = 1'b0;
  logic                aresetn       = 1'b0;
  logic                s_axi_awvalid = 1'b0;
  logic                s_axi_wvalid  = 1'b0;
  logic                s_axi_bready  = 1'b0;
  logic                s_axi_arvalid = 1'b0;
  logic                s_axi_rready  = 1'b0;
  logic [7:0]          s_axi_awaddr  = 8'h00;
  logic [7:0]          s_axi_araddr  = 8'h00;
  logic [31:0]         s_axi_wdata   = 32'h0;
  logic [3:0]          s_axi_wstrb   = 4'hf;
  logic                s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]          s_axi_bresp, s_axi_rresp;
  logic [31:0]         s_axi_rdata, block_protected;
  logic                reset_busy;
  fglr_pkg::fglr_spi_s spi;
  int                  mismatches  = 0;
  int                  checks_done = 0;
  int                  cyc         = 0;
  int                  blen        = 0;

  always #2.5 aclk = ~aclk;

  fglr_host host (.aclk, .spi);
  fglr_cmd #(.RECOVERY_CYC(RC)) dut (.aclk, .aresetn, .spi, .block_protected, .reset_busy,
    .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
    .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp);

  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (reset_busy)
      blen <= blen + 1;
    if (cyc == 20000)
    begin
      mismatches++;
      summarize();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One register access; d is write data or expected read data
  task automatic acc(input int w, input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic [31:0] rd;
    logic [1:0]  rs;
    logic        aok, wok, rok, bok;
    int          n;
    @(posedge aclk);
    s_axi_awvalid <= (w != 0);
    s_axi_wvalid  <= (w != 0);
    s_axi_bready  <= (w != 0);
    s_axi_arvalid <= !w;
    s_axi_rready  <= !w;
    s_axi_awaddr  <= a;
    s_axi_araddr  <= a;
    s_axi_wdata   <= d;
    n   = 0;
    bok = 1'b0;
    // Only the bench timeout ends a wait for the answer
    while (!bok)
    begin
      #1;
      aok = s_axi_awready;
      wok = s_axi_wready;
      rok = s_axi_arready;
      bok = w ? s_axi_bvalid : s_axi_rvalid;
      rs  = w ? s_axi_bresp : s_axi_rresp;
      rd  = s_axi_rdata;
      @(posedge aclk);
      n++;
      if (aok) s_axi_awvalid <= 1'b0;
      if (wok) s_axi_wvalid <= 1'b0;
      if (rok) s_axi_arvalid <= 1'b0;
      if (bok)
      begin
        s_axi_bready <= 1'b0;
        s_axi_rready <= 1'b0;
      end
    end
    chk("latency", (w != 0) ? 32'd3 : 32'd2, n);
    chk("resp", {30'h0, er}, {30'h0, rs});
    if (!w)
      chk("rdata", d, rd);
  endtask

  task automatic t_defaults;
    acc(0, fglr_pkg::ADDR_STATUS, 32'h0, fglr_pkg::RESP_OKAY);
    acc(0, fglr_pkg::ADDR_LOCK0, 32'hffffffff, fglr_pkg::RESP_OKAY);
    chk("block_protected", 32'h0, block_protected);
    acc(0, 8'h10, 32'h0, fglr_pkg::RESP_SLVERR);
    acc(1, 8'h10, 32'h0, fglr_pkg::RESP_SLVERR);
    acc(1, fglr_pkg::ADDR_CTRL, 32'h1, fglr_pkg::RESP_OKAY);
    chk("block_protected", 32'hffffffff, block_protected);
  endtask

  task automatic t_lock;
    host.send(fglr_pkg::OP_GLOBAL_UNLOCK, 8);
    acc(0, fglr_pkg::ADDR_LOCK0, 32'hffffffff, fglr_pkg::RESP_OKAY);
    acc(0, fglr_pkg::ADDR_STATUS, 32'h8, fglr_pkg::RESP_OKAY);
    acc(1, fglr_pkg::ADDR_STATUS, 32'h8, fglr_pkg::RESP_OKAY);
    host.send(fglr_pkg::OP_WRITE_ENABLE, 8);
    host.send(fglr_pkg::OP_GLOBAL_UNLOCK, 7);
    acc(0, fglr_pkg::ADDR_STATUS, 32'h1, fglr_pkg::RESP_OKAY);
    host.send(fglr_pkg::OP_GLOBAL_UNLOCK, 8);
    chk("block_protected", 32'h0, block_protected);
    acc(0, fglr_pkg::ADDR_STATUS, 32'h0, fglr_pkg::RESP_OKAY);
    host.send(fglr_pkg::OP_WRITE_ENABLE, 8);
    host.send(fglr_pkg::OP_GLOBAL_LOCK, 8);
    chk("block_protected", 32'hffffffff, block_protected);
    host.send(fglr_pkg::OP_WRITE_ENABLE, 8);
    host.send(fglr_pkg::OP_GLOBAL_UNLOCK, 8);
    acc(0, fglr_pkg::ADDR_LOCK0, 32'h0, fglr_pkg::RESP_OKAY);
    // Opcodes injected through the command register take the pin path
    acc(1, fglr_pkg::ADDR_CMD, {24'h000000, fglr_pkg::OP_WRITE_ENABLE}, fglr_pkg::RESP_OKAY);
    acc(0, fglr_pkg::ADDR_STATUS, 32'h1, fglr_pkg::RESP_OKAY);
    acc(1, fglr_pkg::ADDR_CMD, {24'h000000, fglr_pkg::OP_WRITE_DISABLE}, fglr_pkg::RESP_OKAY);
    acc(0, fglr_pkg::ADDR_CMD, 32'h0, fglr_pkg::RESP_OKAY);
    acc(0, fglr_pkg::ADDR_STATUS, 32'h0, fglr_pkg::RESP_OKAY);
  endtask

  task automatic t_reset;
    acc(1, fglr_pkg::ADDR_CTRL, 32'h075aa503, fglr_pkg::RESP_OKAY);
    acc(0, fglr_pkg::ADDR_CTRL, 32'h075aa503, fglr_pkg::RESP_OKAY);
    host.send(fglr_pkg::OP_RESET_ENABLE, 8);
    host.send(fglr_pkg::OP_WRITE_ENABLE, 8);
    host.send(fglr_pkg::OP_RESET, 8);
    chk("reset_busy", 32'h0, {31'h0, reset_busy});
    host.send(fglr_pkg::OP_RESET_ENABLE, 8);
    host.send(fglr_pkg::OP_RESET, 8);
    chk("reset_busy", 32'h1, {31'h0, reset_busy});
    host.send(fglr_pkg::OP_WRITE_ENABLE, 8);
    while (reset_busy && cyc < 19000)
      @(posedge aclk);
    chk("recovery", 32'h1, {31'h0, blen >= RC - 1 && blen <= RC + 1});
    acc(0, fglr_pkg::ADDR_CTRL, 32'h0, fglr_pkg::RESP_OKAY);
    acc(0, fglr_pkg::ADDR_STATUS, 32'h8, fglr_pkg::RESP_OKAY);
    acc(0, fglr_pkg::ADDR_LOCK0, 32'hffffffff, fglr_pkg::RESP_OKAY);
    chk("block_protected", 32'h0, block_protected);
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial
  begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    t_defaults();
    t_lock();
    t_reset();
    summarize();
  end
endmodule

bind fglr_cmd fglr_cmd_monitor #(.NUM_LOCKS(NUM_LOCKS), .RECOVERY_CYC(RECOVERY_CYC)) u_mon
  (.aclk(aclk), .aresetn(aresetn), .spi(spi), .block_protected(block_protected), .reset_busy(reset_busy));
`default_nettype wire
